// [verilog/gdf_pkg.sv]
// Package for the gate driver fault manager: register map, field layouts,
// reset values, states and timing constants.
// Assumes a 20 MHz hclk and a 32-bit AHB-Lite register bus.
package gdf_pkg;

   // Clock rate in MHz, used to turn microseconds into cycles.
   localparam int CLK_MHZ = 20;

   // Byte addresses of the registers.
   localparam logic [7:0] ADDR_CTRL   = 8'h00;  // Configuration, read/write.
   localparam logic [7:0] ADDR_STATUS = 8'h04;  // Sticky fault flags, read only.
   localparam logic [7:0] ADDR_CMD    = 8'h08;  // Command strobes, write only.
   localparam logic [7:0] ADDR_STATE  = 8'h0c;  // Live block state, read only.

   // Field positions in the CTRL register.
   localparam int CTRL_PUMP_DIS = 0;   // Pump low protection disable.
   localparam int CTRL_ACTION   = 1;   // Two-bit overcurrent action select.
   localparam int CTRL_DEGLITCH = 3;   // Two-bit deglitch select.
   localparam int CTRL_THRESH   = 5;   // Four-bit drain-source threshold select.
   localparam int CTRL_BR_DIS   = 9;   // Three per-bridge monitor disables.
   localparam int CTRL_WIDTH    = 12;  // Bits used in CTRL.

   // Field positions in the CMD register.
   localparam int CMD_CLEAR = 0;       // Clear faults command bit.

   // Overcurrent action encodings.
   localparam logic [1:0] ACT_LATCH  = 2'h0;
   localparam logic [1:0] ACT_RETRY  = 2'h1;
   localparam logic [1:0] ACT_REPORT = 2'h2;
   localparam logic [1:0] ACT_OFF    = 2'h3;

   // Number of monitored FETs and half-bridges.
   localparam int NUM_FET    = 6;
   localparam int NUM_BRIDGE = 3;

   // Deglitch times in microseconds and their cycle counts.
   localparam int DEG_HW_US  = 4;
   localparam int DEG_US0    = 1;
   localparam int DEG_US1    = 2;
   localparam int DEG_US2    = 4;
   localparam int DEG_US3    = 8;
   localparam logic [7:0] DEG_HW_CYC = 8'(DEG_HW_US * CLK_MHZ);
   localparam logic [7:0] DEG_CYC0   = 8'(DEG_US0 * CLK_MHZ);
   localparam logic [7:0] DEG_CYC1   = 8'(DEG_US1 * CLK_MHZ);
   localparam logic [7:0] DEG_CYC2   = 8'(DEG_US2 * CLK_MHZ);
   localparam logic [7:0] DEG_CYC3   = 8'(DEG_US3 * CLK_MHZ);

   // Retry interval in microseconds; the cycle count is a top parameter.
   localparam int RETRY_US  = 4000;
   localparam int RETRY_W   = 17;

   // Reset value of the configuration register.
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 12'h000;

   // Configuration as software sees it.
   typedef struct packed {
      logic [NUM_BRIDGE-1:0] bridge_monitor_disable;
      logic [3:0]            drain_source_threshold_sel;
      logic [1:0]            overcurrent_deglitch_sel;
      logic [1:0]            overcurrent_action_sel;
      logic                  pump_low_disable;
   } gdf_ctrl_t;

   // Sticky fault flags as software sees them.
   typedef struct packed {
      logic               mem_fault_flag;
      logic [NUM_FET-1:0] fet_oc_flag;
      logic               ds_oc_flag;
      logic               pump_low_flag;
      logic               supply_low_flag;
      logic               any_fault_flag;
   } gdf_flags_t;

   // Overcurrent recovery states.
   typedef enum logic [1:0] {
      OC_RUN,
      OC_SHUT,
      OC_RETRY,
      OC_REPORT
   } gdf_oc_state_t;

endpackage : gdf_pkg

// [verilog/gdf_fault_manager.sv]
// Fault manager for a three-half-bridge gate driver: supply and pump
// lockout, drain-source overcurrent deglitch and recovery, memory fault.
// Assumes comparator and pin inputs are already synchronous to hclk and
// that a single AHB-Lite master reaches the registers.
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns

module gdf_fault_manager
   import gdf_pkg::*;
#(
   parameter logic [RETRY_W-1:0] RETRY_CYC = RETRY_W'(RETRY_US * CLK_MHZ)
) (
   input  wire logic               hclk,             // Block clock, 20 MHz.
   input  wire logic               hresetn,          // Asynchronous reset, active low.
   input  wire logic               hsel,             // AHB slave select.
   input  wire logic [31:0]        haddr,            // AHB address.
   input  wire logic [1:0]         htrans,           // AHB transfer type.
   input  wire logic               hwrite,           // AHB write flag.
   input  wire logic [2:0]         hsize,            // AHB transfer size.
   input  wire logic [31:0]        hwdata,           // AHB write data.
   input  wire logic               hready,           // AHB bus ready.
   output logic [31:0]             hrdata,           // AHB read data.
   output logic                    hreadyout,        // AHB slave ready.
   output logic                    hresp,            // AHB response, always OKAY.
   input  wire logic               hw_variant,       // Strap: pin-strapped variant.
   input  wire logic               strap_at_logic_supply, // Threshold strap tied high.
   input  wire logic               supply_low,       // Motor supply below lockout.
   input  wire logic               pump_low,         // Pump output undervoltage.
   input  wire logic               checksum_fail,    // Memory checksum failed.
   input  wire logic               enable_pin,       // Enable pin level.
   input  wire logic [NUM_FET-1:0] fet_on,           // FET commanded on.
   input  wire logic [NUM_FET-1:0] ds_over,          // Drain-source above threshold.
   output logic                    gate_enable,      // Gate drivers may drive.
   output logic                    pump_enable,      // Charge pump runs.
   output logic [3:0]              ds_threshold,     // Threshold code to comparators.
   output logic                    fault_out_n,      // Fault pin output value.
   output logic                    fault_out_oe      // Fault pin driven low when high.
);

   // Configuration register and its structured view.
   logic [CTRL_WIDTH-1:0] ctrl_q;
   gdf_ctrl_t             cfg;

   // Strap capture, taken on the first edge after reset release.
   logic                  strap_done_q;
   logic                  hw_q;
   logic                  strap_off_q;

   // AHB data-phase bookkeeping.
   logic                  wr_pend_q;
   logic [7:0]            wr_addr_q;
   logic [31:0]           rdata_q;
   logic                  addr_phase;

   // Effective configuration after the variant is applied.
   logic [1:0]            act_eff;
   logic [7:0]            deg_eff;
   logic                  pump_prot;
   logic                  monitor_off;

   // Clear sources.
   logic                  clear_cmd;
   logic                  enable_prev_q;
   logic                  enable_pulse;
   logic                  clear_any;

   // Overcurrent detection.
   logic [NUM_FET-1:0]    oc_live;
   logic [NUM_FET-1:0]    oc_event;
   logic                  oc_any_live;

   // Overcurrent recovery state.
   gdf_oc_state_t         oc_state_q;
   logic [RETRY_W-1:0]    retry_cnt_q;
   logic                  retry_done;

   // Sticky flags.
   gdf_flags_t            flags_q;
   logic                  mem_fault_q;

   // Live fault-pin and shutdown terms.
   logic                  gate_off_d;
   logic                  fault_d;

   // Structured view of CTRL and the qualifier of an AHB address phase.
   assign cfg        = gdf_ctrl_t'(ctrl_q);
   assign addr_phase = hsel & htrans[1] & hready;

   // The strap is a level caught after reset release, never under reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_done_q <= 1'b0;
         hw_q         <= 1'b0;
         strap_off_q  <= 1'b0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         hw_q         <= hw_variant;
         strap_off_q  <= strap_at_logic_supply;
      end
   end

   // Pick the live configuration for the variant in use.
   always_comb begin
      if (hw_q) begin
         act_eff     = ACT_LATCH;
         deg_eff     = DEG_HW_CYC;
         pump_prot   = 1'b1;
         monitor_off = strap_off_q;
      end else begin
         act_eff     = cfg.overcurrent_action_sel;
         pump_prot   = ~cfg.pump_low_disable;
         monitor_off = (cfg.overcurrent_action_sel == ACT_OFF);
         case (cfg.overcurrent_deglitch_sel)
            2'h0:    deg_eff = DEG_CYC0;
            2'h1:    deg_eff = DEG_CYC1;
            2'h2:    deg_eff = DEG_CYC2;
            default: deg_eff = DEG_CYC3;
         endcase
      end
   end

   // Register the address phase of each AHB transfer; reads answer at once.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rdata_q   <= 32'h0000_0000;
      end else begin
         wr_pend_q <= addr_phase & hwrite;
         wr_addr_q <= haddr[7:0];
         if (addr_phase && !hwrite) begin
            case (haddr[7:0])
               ADDR_CTRL:   rdata_q <= 32'(ctrl_q);
               ADDR_STATUS: rdata_q <= 32'(flags_q);
               ADDR_STATE:  rdata_q <= 32'({hw_q, oc_state_q, fault_out_oe,
                                            pump_enable, gate_enable});
               default:     rdata_q <= 32'h0000_0000;  // Unmapped reads zero.
            endcase
         end
      end
   end

   // Zero-wait slave: ready and OKAY are constant flops.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Read data comes straight from its register, so it holds through the data phase.
   assign hrdata = rdata_q;

   // Configuration writes; bridge disables are frozen while action is off.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_pend_q && wr_addr_q == ADDR_CTRL) begin
         ctrl_q[CTRL_BR_DIS-1:0] <= hwdata[CTRL_BR_DIS-1:0];
         if (cfg.overcurrent_action_sel != ACT_OFF) begin
            ctrl_q[CTRL_WIDTH-1:CTRL_BR_DIS] <= hwdata[CTRL_WIDTH-1:CTRL_BR_DIS];
         end
      end
   end

   // Clear command is a write of one to the command bit.
   assign clear_cmd = wr_pend_q & (wr_addr_q == ADDR_CMD) & hwdata[CMD_CLEAR];

   // Enable reset pulse ends on the rising edge of the enable pin.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_prev_q <= 1'b1;
      end else begin
         enable_prev_q <= enable_pin;
      end
   end

   // A rising edge of the enable pin after any low time counts as a reset pulse.
   assign enable_pulse = enable_pin & ~enable_prev_q;
   assign clear_any    = clear_cmd | enable_pulse;

   // One deglitch counter per FET; it restarts when the condition drops.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_FET; gi++) begin : g_deg
         logic [7:0] cnt_q;
         assign oc_live[gi] = ds_over[gi] & fet_on[gi] & ~monitor_off &
                              ~(cfg.bridge_monitor_disable[gi/2] & ~hw_q);
         // The compare is at or above the limit, so that a shorter deglitch
         // setting written mid-count still trips at once instead of never.
         assign oc_event[gi] = oc_live[gi] & (cnt_q >= deg_eff);
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               cnt_q <= 8'h00;
            end else if (!oc_live[gi]) begin
               cnt_q <= 8'h00;
            end else if (cnt_q < deg_eff) begin
               cnt_q <= cnt_q + 8'h01;
            end
         end
      end
   endgenerate

   // Any FET whose deglitch count has expired starts the recovery sequence.
   assign oc_any_live = |oc_event;
   assign retry_done  = (retry_cnt_q == RETRY_CYC);

   // Overcurrent recovery sequence for the selected action.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oc_state_q <= OC_RUN;
      end else begin
         case (oc_state_q)
            OC_RUN: begin
               // A disabled action leaves the state where it is.
               if (oc_any_live) begin
                  case (act_eff)
                     ACT_LATCH:  oc_state_q <= OC_SHUT;
                     ACT_RETRY:  oc_state_q <= OC_RETRY;
                     ACT_REPORT: oc_state_q <= OC_REPORT;
                     default:    oc_state_q <= OC_RUN;
                  endcase
               end
            end
            OC_SHUT, OC_REPORT: begin
               // Leave only once the condition is gone and a clear arrives.
               if (clear_any && !(|oc_live)) begin
                  oc_state_q <= OC_RUN;
               end
            end
            OC_RETRY: begin
               if (retry_done) begin
                  oc_state_q <= OC_RUN;
               end
            end
            default: oc_state_q <= OC_RUN;
         endcase
      end
   end

   // Retry interval counter runs only while waiting to retry.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         retry_cnt_q <= '0;
      end else if (oc_state_q == OC_RETRY && !retry_done) begin
         retry_cnt_q <= retry_cnt_q + RETRY_W'(1);
      end else begin
         retry_cnt_q <= '0;
      end
   end

   // Memory fault is held from the checksum result; it has no recovery.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_fault_q <= 1'b0;
      end else if (checksum_fail) begin
         mem_fault_q <= 1'b1;
      end
   end

   // Sticky flags; a new event wins over a clear in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_q <= '0;
      end else begin
         if (supply_low) begin
            flags_q.supply_low_flag <= 1'b1;
         end else if (clear_any) begin
            flags_q.supply_low_flag <= 1'b0;
         end
         if (pump_low) begin
            flags_q.pump_low_flag <= 1'b1;
         end else if (clear_any) begin
            flags_q.pump_low_flag <= 1'b0;
         end
         if (oc_any_live && act_eff != ACT_OFF) begin
            flags_q.ds_oc_flag  <= 1'b1;
            flags_q.fet_oc_flag <= flags_q.fet_oc_flag | oc_event;
         end else if ((oc_state_q == OC_RETRY && retry_done) ||
                      (oc_state_q != OC_RETRY && clear_any && !(|oc_live))) begin
            flags_q.ds_oc_flag  <= 1'b0;
            flags_q.fet_oc_flag <= '0;
         end
         flags_q.mem_fault_flag <= mem_fault_q;
         // The global flag is rebuilt every cycle, one cycle behind the others.
         flags_q.any_fault_flag <= flags_q.supply_low_flag | flags_q.pump_low_flag |
                                   flags_q.ds_oc_flag | (|flags_q.fet_oc_flag) |
                                   flags_q.mem_fault_flag;
      end
   end

   // Live shutdown and fault pin terms.
   always_comb begin
      gate_off_d = supply_low
                 | (pump_low & pump_prot)
                 | (oc_state_q == OC_SHUT) | (oc_state_q == OC_RETRY);
      fault_d    = gate_off_d
                 | (oc_state_q == OC_REPORT)
                 | mem_fault_q;
   end

   // Outputs come straight from flops; the pump stops only on supply low.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_enable  <= 1'b0;
         pump_enable  <= 1'b0;
         ds_threshold <= 4'h0;
         fault_out_n  <= 1'b1;
         fault_out_oe <= 1'b0;
      end else begin
         gate_enable  <= ~gate_off_d;
         pump_enable  <= ~supply_low;
         ds_threshold <= cfg.drain_source_threshold_sel;
         fault_out_n  <= ~fault_d;
         fault_out_oe <= fault_d;
      end
   end

endmodule // gdf_fault_manager

// [sim/gdf_fault_manager_properties.sv]
// Checker for the fault manager, watching only the ports of the top module.
// Assumes the strap inputs change only while hresetn is low.
`timescale 1ns/1ns
module gdf_fault_manager_properties
   import gdf_pkg::*;
(
   input wire logic               hclk,
   input wire logic               hresetn,
   input wire logic               hw_variant,
   input wire logic               strap_at_logic_supply,
   input wire logic               supply_low,
   input wire logic               pump_low,
   input wire logic               checksum_fail,
   input wire logic [NUM_FET-1:0] fet_on,
   input wire logic [NUM_FET-1:0] ds_over,
   input wire logic               gate_enable,
   input wire logic               pump_enable,
   input wire logic               fault_out_n,
   input wire logic               fault_out_oe
);
   logic [1:0] up_q;   // Edges since reset release, saturating, so straps are settled.
   logic [7:0] run_q;  // Consecutive cycles with an enabled FET over threshold.

   // Counts edges after reset until the straps are surely captured.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   end

   // Counts how long the overcurrent condition has held without a break.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) run_q <= 8'h00;
      else if (!(|(ds_over & fet_on))) run_q <= 8'h00;
      else if (run_q != 8'hff) run_q <= run_q + 8'h01;
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_supply_off;
      supply_low |=> !gate_enable && !pump_enable && !fault_out_n;
   endproperty
   a_supply_off: assert property (p_supply_off) else $error("supply low not shut");
   property p_pin_oe;
      fault_out_oe == !fault_out_n;
   endproperty
   a_pin_oe: assert property (p_pin_oe) else $error("pin enable mismatch");
   property p_pump_back;
      !supply_low |=> pump_enable;
   endproperty
   a_pump_back: assert property (p_pump_back) else $error("pump not resumed");
   property p_pump_hw;
      up_q == 2'h3 && hw_variant && pump_low |=> !gate_enable && !fault_out_n;
   endproperty
   a_pump_hw: assert property (p_pump_hw) else $error("pump protection off");
   property p_mem;
      checksum_fail |-> ##2 !fault_out_n;
   endproperty
   a_mem: assert property (p_mem) else $error("memory fault not shown");
   property p_deglitch;
      $fell(gate_enable) |-> $past(supply_low) || $past(pump_low) || $past(run_q, 2) >= 8'd19;
   endproperty
   a_deglitch: assert property (p_deglitch) else $error("early shutdown");
   property p_hw_deg;
      up_q == 2'h3 && hw_variant && $fell(gate_enable)
         |-> $past(supply_low) || $past(pump_low) || $past(run_q, 2) >= 8'd79;
   endproperty
   a_hw_deg: assert property (p_hw_deg) else $error("fixed deglitch broken");
   property p_hw_strap;
      up_q == 2'h3 && hw_variant && strap_at_logic_supply && $fell(gate_enable)
         |-> $past(supply_low) || $past(pump_low);
   endproperty
   a_hw_strap: assert property (p_hw_strap) else $error("monitor not disabled");

   c_supply: cover property (supply_low ##1 !gate_enable);
   c_pin: cover property ($fell(fault_out_n));
   c_oc: cover property (run_q > 8'd20 && !gate_enable);
endmodule // gdf_fault_manager_properties

bind gdf_fault_manager gdf_fault_manager_properties u_props (
   .hclk(hclk), .hresetn(hresetn), .hw_variant(hw_variant),
   .strap_at_logic_supply(strap_at_logic_supply), .supply_low(supply_low),
   .pump_low(pump_low), .checksum_fail(checksum_fail), .fet_on(fet_on), .ds_over(ds_over),
   .gate_enable(gate_enable), .pump_enable(pump_enable), .fault_out_n(fault_out_n),
   .fault_out_oe(fault_out_oe));

// [sim/gdf_fault_pin_model.sv]
// Controller-side view of the open-drain fault pin.
// Assumes an external pull-up, so the wire is high unless the block drives it.
`timescale 1ns/1ns
module gdf_fault_pin_model (
   input wire logic fault_out_n,
   input wire logic fault_out_oe,
   output logic     fault_wire
);
   // The pull-up wins whenever the driver is off.
   assign fault_wire = fault_out_oe ? fault_out_n : 1'b1;
endmodule // gdf_fault_pin_model

// [sim/gdf_fault_manager_tb.sv]
// Self-checking bench: AHB-Lite register access and fault pin stimulus.
// Assumes a zero-wait slave and a shortened retry interval.
`timescale 1ns/1ns
module gdf_fault_manager_tb;
   import gdf_pkg::*;
   localparam logic [RETRY_W-1:0] RETRY = 17'd50;  // Short retry interval for simulation.
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready = 1'b1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        hw_variant = 1'b0, strap = 1'b0, supply_low = 1'b0, pump_low = 1'b0;
   logic        checksum_fail = 1'b0, enable_pin = 1'b1;
   logic [5:0]  fet_on = 6'h0, ds_over = 6'h0;
   logic [31:0] hrdata;
   logic [3:0]  ds_threshold;
   logic        hreadyout, hresp, gate_enable, pump_enable, fault_out_n, fault_out_oe, fw;
   int          fail_count = 0, comparisons = 0, deg;

   gdf_fault_manager #(.RETRY_CYC(RETRY)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .hw_variant(hw_variant), .strap_at_logic_supply(strap), .supply_low(supply_low),
      .pump_low(pump_low), .checksum_fail(checksum_fail), .enable_pin(enable_pin),
      .fet_on(fet_on), .ds_over(ds_over), .gate_enable(gate_enable),
      .pump_enable(pump_enable), .ds_threshold(ds_threshold), .fault_out_n(fault_out_n),
      .fault_out_oe(fault_out_oe));
   gdf_fault_pin_model u_pin (.fault_out_n(fault_out_n), .fault_out_oe(fault_out_oe),
      .fault_wire(fw));

   // Free-running 20 MHz clock.
   always #25 hclk = ~hclk;

   // Prints the verdict and ends the run.
   task automatic finish_test;
      if (fail_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Compares one value and reports a mismatch.
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Waits for hreadyout high at a rising edge, bounded.
   task automatic wready;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
         fail_count++;
         finish_test;
      end
   endtask
   // One single word transfer: address phase, then data phase.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      wready;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wready;
      rd = hrdata;
   endtask
   task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, e, rd);
      chk({n, " resp"}, 32'h0, {31'h0, hresp});
   endtask
   // Checks the gate enable and the fault wire level together.
   task automatic pins(input string n, input logic g, input logic f);
      chk({n, " gate"}, {31'h0, g}, {31'h0, gate_enable});
      chk({n, " pin"}, {31'h0, f}, {31'h0, fw});
   endtask
   // Clears faults by command write or by an enable pulse.
   task automatic clr(input logic pulse);
      if (pulse) begin
         enable_pin <= 1'b0;
         tick(2);
         enable_pin <= 1'b1;
      end else begin
         bus(1'b1, ADDR_CMD, 32'h1);
      end
      tick(4);
   endtask
   task automatic rst(input logic h, input logic s);
      hresetn <= 1'b0;
      hw_variant <= h;
      strap <= s;
      tick(4);
      hresetn <= 1'b1;
      tick(3);
   endtask
   task automatic oc(input int n);
      fet_on <= 6'h04;
      ds_over <= 6'h04;
      tick(n);
   endtask
   task automatic oc_off;
      fet_on <= 6'h00;
      ds_over <= 6'h00;
      tick(2);
   endtask

   // Cuts a hang short.
   initial begin
      #2000000;
      fail_count++;
      finish_test;
   end

   // Main sequence.
   initial begin
      rst(1'b0, 1'b0);
      rdchk("ctrl", ADDR_CTRL, 32'h0);
      bus(1'b1, 8'h10, 32'hffff);
      rdchk("unmapped", 8'h10, 32'h0);
      pins("idle", 1'b1, 1'b1);
      supply_low <= 1'b1;
      tick(3);
      pins("supply", 1'b0, 1'b0);
      chk("pump", 32'h0, {31'h0, pump_enable});
      rdchk("supply flags", ADDR_STATUS, 32'h3);
      supply_low <= 1'b0;
      tick(3);
      pins("supply back", 1'b1, 1'b1);
      rdchk("supply sticky", ADDR_STATUS, 32'h3);
      clr(1'b0);
      rdchk("supply clr", ADDR_STATUS, 32'h0);
      pump_low <= 1'b1;
      tick(3);
      pins("pump", 1'b0, 1'b0);
      pump_low <= 1'b0;
      tick(3);
      pins("pump back", 1'b1, 1'b1);
      rdchk("pump flags", ADDR_STATUS, 32'h5);
      clr(1'b1);
      rdchk("pump clr", ADDR_STATUS, 32'h0);
      bus(1'b1, ADDR_CTRL, 32'h1);
      pump_low <= 1'b1;
      tick(4);
      pins("pump off", 1'b1, 1'b1);
      pump_low <= 1'b0;
      tick(2);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("pump only", 32'h4, rd & 32'h6);
      clr(1'b0);
      rdchk("pump off clr", ADDR_STATUS, 32'h0);
      for (int i = 0; i < 4; i++) begin
         deg = (DEG_US0 * CLK_MHZ) << i;
         bus(1'b1, ADDR_CTRL, (32'(i) << CTRL_DEGLITCH) | (32'ha << CTRL_THRESH));
         tick(2);
         chk("threshold", 32'ha, {28'h0, ds_threshold});
         oc(deg - 4);
         pins("deg early", 1'b1, 1'b1);
         oc(10);
         pins("deg trip", 1'b0, 1'b0);
         rdchk("oc flags", ADDR_STATUS, 32'h49);
         clr(1'b0);
         pins("oc held", 1'b0, 1'b0);
         oc_off;
         clr(1'b1);
         pins("oc clr", 1'b1, 1'b1);
      end
      bus(1'b1, ADDR_CTRL, 32'h0);
      oc(15);
      ds_over <= 6'h00;
      tick(1);
      oc(15);
      pins("glitch", 1'b1, 1'b1);
      fet_on <= 6'h00;
      ds_over <= 6'h3f;
      tick(40);
      pins("fet off", 1'b1, 1'b1);
      oc_off;
      bus(1'b1, ADDR_CTRL, 32'h2);
      oc(25);
      oc_off;
      pins("retry", 1'b0, 1'b0);
      rdchk("retry flags", ADDR_STATUS, 32'h49);
      tick(int'(RETRY) + 5);
      pins("retry back", 1'b1, 1'b1);
      rdchk("retry clr", ADDR_STATUS, 32'h0);
      bus(1'b1, ADDR_CTRL, 32'h4);
      oc(25);
      pins("report", 1'b1, 1'b0);
      oc_off;
      pins("report held", 1'b1, 1'b0);
      rdchk("state", ADDR_STATE, 32'h1f);
      clr(1'b0);
      pins("report clr", 1'b1, 1'b1);
      bus(1'b1, ADDR_CTRL, 32'h400);
      rdchk("bridge", ADDR_CTRL, 32'h400);
      oc(40);
      pins("bridge off", 1'b1, 1'b1);
      oc_off;
      bus(1'b1, ADDR_CTRL, 32'h6);
      oc(60);
      pins("oc off", 1'b1, 1'b1);
      oc_off;
      bus(1'b1, ADDR_CTRL, 32'he06);
      rdchk("locked", ADDR_CTRL, 32'h6);
      rdchk("oc off flags", ADDR_STATUS, 32'h0);
      rst(1'b1, 1'b0);
      bus(1'b1, ADDR_CTRL, 32'h5);
      pump_low <= 1'b1;
      tick(3);
      pins("hw pump", 1'b0, 1'b0);
      pump_low <= 1'b0;
      tick(3);
      clr(1'b0);
      oc(76);
      pins("hw early", 1'b1, 1'b1);
      oc(10);
      pins("hw trip", 1'b0, 1'b0);
      oc_off;
      pins("hw latched", 1'b0, 1'b0);
      clr(1'b1);
      pins("hw clr", 1'b1, 1'b1);
      rst(1'b1, 1'b1);
      oc(200);
      pins("hw strap", 1'b1, 1'b1);
      oc_off;
      checksum_fail <= 1'b1;
      tick(3);
      pins("mem", 1'b1, 1'b0);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("mem flags", 32'h401, rd & 32'h401);
      finish_test;
   end
endmodule // gdf_fault_manager_tb
